// ---- logic/rdc_relay_driver_control.v ----
// Relay driver control: serial and parallel latch variants with set/reset
`timescale 1ns/1ps
`include "rdc_defines.vh"
module rdc_relay_driver_control #(
    parameter CHANNELS = `RDC_CHANNELS,
    parameter MODE = `RDC_MODE_SERIAL
) (
    input wire sys_clk,
    input wire rst_n,
    input wire globalResetN,
    input wire globalSetN,
    input wire chipSelectN,
    input wire serialClock,
    input wire serialDataIn,
    output reg serialDataOut,
    input wire selectBitLow,
    input wire selectBitMid,
    input wire selectBitHigh,
    input wire outputLevel,
    output wire [CHANNELS-1:0] relayOut,
    output wire [CHANNELS-1:0] relayOutEn,
    output wire [CHANNELS-1:0] latchState
);
    // Pin bundle width, and a select width that covers eight channels
    localparam NSYNC = 8;
    localparam SELW = `RDC_SEL_WIDTH;

    // Raw and synchronised pin copies, and the controls decoded from them
    wire [NSYNC-1:0] pinRaw;
    wire [NSYNC-1:0] pinSync;
    wire resetActive;
    wire setActive;
    wire csSync;
    wire sclkSync;
    wire dinSync;
    wire [SELW-1:0] selIndex;
    wire levelSync;

    // Edge history and the strobes found from it
    reg csPrev_reg;
    reg sclkPrev_reg;
    wire csRise;
    wire sclkRise;
    wire sclkFall;
    wire shiftEnable;

    // Shifter, latch and cascade state with their next values
    reg [CHANNELS-1:0] shift_reg;
    reg [CHANNELS-1:0] shift_next;
    reg [CHANNELS-1:0] latch_reg;
    reg [CHANNELS-1:0] latch_next;
    reg doutNext;

    // Parallel capture and its per-channel decode
    reg [SELW-1:0] selCap_reg;
    reg levelCap_reg;
    wire [CHANNELS-1:0] selHit;
    wire [CHANNELS-1:0] parallelNext;

    // One bundle for the control, serial and select pins; all see the same
    // two-clock delay, so their relative timing at the pins is kept
    assign pinRaw = {globalResetN, globalSetN, chipSelectN, serialClock,
                     serialDataIn, selectBitHigh, selectBitMid,
                     selectBitLow};

    // All pins cross into sys_clk through two flops
    rdc_sync #(
        .WIDTH(NSYNC)
    ) uPinSync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn(pinRaw),
        .syncOut(pinSync)
    );

    // Level pin has its own pair so the bundle stays eight wide
    rdc_sync #(
        .WIDTH(1)
    ) uLevelSync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn(outputLevel),
        .syncOut(levelSync)
    );

    // Synchroniser resets to zero, so pins read as asserted until settled;
    // reset-asserted is the safe side for relays. Set is masked by reset
    // here so that the priority holds even for a single overlapping clock,
    // not only once both pins have settled
    assign resetActive = !pinSync[7];
    assign setActive = !pinSync[6] && !resetActive;
    assign csSync = pinSync[5];
    assign sclkSync = pinSync[4];
    assign dinSync = pinSync[3];
    assign selIndex = pinSync[SELW-1:0];

    // Edge finders on the synchronised copies only; a raw pin never reaches
    // logic, so each edge is seen two clocks late; bounces are not filtered.
    // After rst_n the select copy climbs from zero, giving one rise while
    // shifter and capture still hold zeros: it latches zeros, which is the
    // state reset left anyway
    assign csRise = csSync && !csPrev_reg;
    assign sclkRise = sclkSync && !sclkPrev_reg;
    assign sclkFall = !sclkSync && sclkPrev_reg;

    // Shifting needs select low; with select high the clock is ignored
    assign shiftEnable = !csSync && sclkRise;

    // Next state: reset beats set, set beats every interface input.
    // Priority lives in one chain so no pin timing lets a latch edge
    // slip through while set or reset is held
    always @* begin
        shift_next = shift_reg;
        latch_next = latch_reg;
        if (resetActive) begin
            shift_next = `RDC_LATCH_RESET;
            latch_next = `RDC_LATCH_RESET;
        end else if (setActive) begin
            shift_next = `RDC_LATCH_SET;
            latch_next = `RDC_LATCH_SET;
        end else if (MODE == `RDC_MODE_SERIAL) begin
            // First bit in ends at the top, so bit 7 is the first sent;
            // extra bits simply fall off the top end
            if (shiftEnable) begin
                shift_next = {shift_reg[CHANNELS-2:0], dinSync};
            end
            // Latch only on select rise, whatever the serial clock does
            if (csRise) begin
                latch_next = shift_reg;
            end
        end else begin
            // Values captured while select was low are applied on its rise
            if (csRise) begin
                latch_next = parallelNext;
            end
        end
    end

    // Cascade output follows the top stage on serial clock fall, so a
    // chained part sampling on the rise sees a settled bit; it is forced
    // along with the latches during set and reset
    always @* begin
        doutNext = serialDataOut;
        if (resetActive) begin
            doutNext = 1'b0;
        end else if (setActive) begin
            doutNext = 1'b1;
        end else if (MODE == `RDC_MODE_SERIAL && sclkFall) begin
            doutNext = shift_reg[CHANNELS-1];
        end
    end

    // Edge history; select idles high so its history starts high too
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            csPrev_reg <= 1'b1;
            sclkPrev_reg <= 1'b0;
        end else begin
            csPrev_reg <= csSync;
            sclkPrev_reg <= sclkSync;
        end
    end

    // Shifter, latch and cascade flops; all priority is decided upstream
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_reg <= `RDC_LATCH_RESET;
            latch_reg <= `RDC_LATCH_RESET;
            serialDataOut <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            latch_reg <= latch_next;
            serialDataOut <= doutNext;
        end
    end

    // Parallel capture tracks the pins while select is low, so the value
    // present just before the rising edge is the one applied; it freezes
    // on the edge itself because select already reads high there
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            selCap_reg <= {SELW{1'b0}};
            levelCap_reg <= 1'b0;
        end else if (!csSync) begin
            selCap_reg <= selIndex;
            levelCap_reg <= levelSync;
        end
    end

    // Per-channel slice: parallel decode and open-drain drive. The output
    // value is always low; the enable alone decides whether the pin sinks
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gDrive
            // Channel index at select width; index zero is output 1
            localparam [SELW-1:0] IDX = ch;
            assign selHit[ch] = (selCap_reg == IDX);
            // Hit takes the captured level, every other bit keeps its state
            assign parallelNext[ch] = selHit[ch] ? levelCap_reg :
                                      latch_reg[ch];
            assign relayOut[ch] = 1'b0;
            assign relayOutEn[ch] = latch_reg[ch];
        end
    endgenerate

    assign latchState = latch_reg;
endmodule

// ---- logic/rdc_defines.vh ----
// Shared constants for the relay driver control block
`ifndef RDC_DEFINES_VH
`define RDC_DEFINES_VH
`define RDC_CHANNELS 8
`define RDC_SEL_WIDTH 3
`define RDC_LATCH_RESET 8'h00
`define RDC_LATCH_SET 8'hff
`define RDC_MODE_SERIAL 1'b0
`define RDC_MODE_PARALLEL 1'b1
`endif

// ---- logic/rdc_sync.v ----
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module rdc_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    // First stage feeds only the second stage, guarding metastability
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule

// ---- testbench/rdc_props_properties.sv ----
// Checker of the relay driver control pins
`timescale 1ns/1ps
module rdc_props #(parameter CHANNELS = 8) (
    input wire sys_clk, rst_n, globalResetN, globalSetN,
    input wire chipSelectN, serialClock, serialDataOut,
    input wire [CHANNELS-1:0] relayOut, relayOutEn, latchState
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Windows are long enough for the two-flop pin synchronisers
    sequence s_set; (globalResetN && !globalSetN)[*6]; endsequence
    sequence s_clr; (!globalResetN)[*5]; endsequence
    sequence s_free; (globalResetN && globalSetN)[*6]; endsequence
    property p_odr; relayOut == '0; endproperty
    a_odr: assert property (p_odr) else $error("pin high");
    property p_set; s_set |-> &latchState && serialDataOut; endproperty
    a_set: assert property (p_set) else $error("set");
    property p_blk; s_set |=> $stable(relayOutEn); endproperty
    a_blk: assert property (p_blk) else $error("set hold");
    property p_both; (!globalResetN && !globalSetN)[*5] |->
        latchState == '0; endproperty
    a_both: assert property (p_both) else $error("both");
    property p_clr; s_clr |-> relayOutEn == '0 && !serialDataOut;
    endproperty
    a_clr: assert property (p_clr) else $error("reset");
    property p_ign; s_clr |=> $stable(latchState); endproperty
    a_ign: assert property (p_ign) else $error("reset hold");
    property p_hold; (s_free and $stable(chipSelectN)[*6]) |=>
        $stable(latchState); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_dout; (s_free and serialClock[*4]) |->
        $stable(serialDataOut); endproperty
    a_dout: assert property (p_dout) else $error("dout");
endmodule
bind rdc_relay_driver_control rdc_props #(.CHANNELS(CHANNELS)) u_p (.*);

// ---- testbench/rdc_host.sv ----
// Host model driving select, serial and parallel pins
`timescale 1ns/1ps
module rdc_host (
    output reg csN = 1'b1,
    output reg sclk = 1'b0,
    output reg din = 1'b0,
    output reg [2:0] sel = 3'h0,
    output reg level = 1'b0
);
    task open;
        csN = 1'b0;
        #200;
    endtask
    // Msb first; data settles a half period before each rise
    task bits(input [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            din = d[i];
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
    endtask
    // Released data flips so a stale bit never looks valid
    task close;
        #100 csN = 1'b1;
        din = ~din;
        #300;
    endtask
    // Select and level settle well before select falls and stay put past
    // its rise, so the sampled value is unambiguous
    task pins(input [2:0] idx, input lvl);
        sel = idx;
        level = lvl;
        #300;
    endtask
    task pick(input [2:0] idx, input lvl);
        pins(idx, lvl);
        csN = 1'b0;
        #200 csN = 1'b1;
        #300;
    endtask
endmodule

// ---- testbench/tb_top.sv ----
// Bench: serial and parallel variants, set/reset priority, cascade output
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errCount++; \
    $display("unexpected %0t got %h want %h", $time, a, b); end end
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, resN = 1'b1, setN = 1'b1;
    wire csN, sclk, din, dout;
    wire [7:0] rOut, rEn, latch;
    int errCount = 0, nTests = 0;
    wire [2:0] sel;
    wire lvl, doutP;
    wire [7:0] rOutP, rEnP, latP;
    rdc_host host (.csN(csN), .sclk(sclk), .din(din), .sel(sel),
        .level(lvl));
    rdc_relay_driver_control dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .globalResetN(resN), .globalSetN(setN), .chipSelectN(csN),
        .serialClock(sclk), .serialDataIn(din), .serialDataOut(dout),
        .selectBitLow(sel[0]), .selectBitMid(sel[1]),
        .selectBitHigh(sel[2]), .outputLevel(lvl), .relayOut(rOut),
        .relayOutEn(rEn), .latchState(latch));
    // Parallel variant shares every pin; it ignores serial clock and data
    rdc_relay_driver_control #(.MODE(1)) dutPar (.sys_clk(sys_clk),
        .rst_n(rst_n), .globalResetN(resN), .globalSetN(setN),
        .chipSelectN(csN), .serialClock(sclk), .serialDataIn(din),
        .serialDataOut(doutP), .selectBitLow(sel[0]),
        .selectBitMid(sel[1]), .selectBitHigh(sel[2]),
        .outputLevel(lvl), .relayOut(rOutP), .relayOutEn(rEnP),
        .latchState(latP));
    // Free-running 40 MHz clock
    initial forever #12.5 sys_clk = ~sys_clk;
    task conclude;
        $display("errors %0d checks %0d", errCount, nTests);
        if (errCount == 0 && nTests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog: the sequence needs about 20 us
    initial begin
        #100000 errCount++;
        conclude();
    end
    task frame(input [7:0] d);
        host.open();
        host.bits(d);
        host.close();
    endtask
    // Inputs move 1.5 ns after a clock edge throughout
    initial begin
        #239 rst_n = 1'b1;
        #100 frame(8'ha5);
        `CHK(rEn, 8'ha5)
        host.open();
        host.bits(8'h11);
        `CHK(rEn, 8'ha5)
        host.bits(8'h96);
        host.close();
        `CHK(latch, 8'h96)
        `CHK(dout, 1'b1)
        host.bits(8'h3c);
        #300 `CHK(rEn, 8'h96)
        setN = 1'b0;
        frame(8'h00);
        `CHK(latch, 8'hff)
        `CHK({doutP, latP}, 9'h1ff)
        `CHK({rOut, rOutP}, 16'h0000)
        resN = 1'b0;
        #300 `CHK(rEn, 8'h00)
        `CHK(rEnP, 8'h00)
        setN = 1'b1;
        frame(8'h7e);
        `CHK(latch, 8'h00)
        resN = 1'b1;
        #300 frame(8'h7e);
        `CHK(rEn, 8'h7e)
        // Parallel: picks build a pattern; a move with select high is ignored
        host.pick(3'h5, 1'b1);
        `CHK(latP, 8'h20)
        host.pick(3'h7, 1'b1);
        `CHK(latP, 8'ha0)
        host.pick(3'h0, 1'b1);
        `CHK(latP, 8'ha1)
        host.pins(3'h2, 1'b1);
        `CHK(latP, 8'ha1)
        host.pick(3'h5, 1'b0);
        `CHK({rEn, latP}, 16'h7e81)
        conclude();
    end
endmodule
